// *** hdl/lswt_div.sv ***
// Divide-by-(limit+1) tick divider, one pulse per wrap.
// Assumes tick_in is a one-cycle pulse on the system clock.
`timescale 1ns/1ns
module lswt_div (
  input  wire logic       mclk_in,
  input  wire logic       srst_in,
  input  wire logic       clear_in,
  input  wire logic       tick_in,
  input  wire logic [5:0] limit_in,
  output logic            pulse_out
);
  logic [5:0] cnt_reg;

  // Clear dominates so a stopped chain restarts from zero
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || clear_in)
      cnt_reg <= 6'h00;
    else if (tick_in)
      cnt_reg <= (cnt_reg >= limit_in) ? 6'h00 : cnt_reg + 6'h01;
  end

  assign pulse_out = tick_in && !clear_in && (cnt_reg >= limit_in);
endmodule

// *** hdl/lswt_map.svh ***
// Register offsets, field positions and reset values of the time base.
// Assumes a 32-bit AXI4-Lite register window with byte addresses.
`ifndef LSWT_MAP_SVH
`define LSWT_MAP_SVH
`define LSWT_OFF_CTRL   8'h00
`define LSWT_OFF_PRESC  8'h04
`define LSWT_OFF_TBASE  8'h08
`define LSWT_OFF_TONE   8'h0C
`define LSWT_OFF_EXTI   8'h10
`define LSWT_OFF_STAT   8'h14
`define LSWT_OFF_CAPT   8'h18
`define LSWT_CTRL_WEN   0
`define LSWT_CTRL_MEAS  1
`define LSWT_CTRL_AUTO  2
`define LSWT_CTRL_SRC   3
`define LSWT_TONE_EN    5
`define LSWT_RST_CTRL   4'h0
`define LSWT_RST_PRESC  6'h00
`define LSWT_RST_TBASE  4'h0
`define LSWT_RST_TONE   8'h1E
`define LSWT_RST_EXTI   6'h00
`define LSWT_SENSE_RISE 2'h1
`define LSWT_SENSE_FALL 2'h2
`define LSWT_RESP_OKAY  2'h0
`define LSWT_RESP_SLV   2'h2
`endif

// *** hdl/lswt_pkg.sv ***
// Types shared by the time base modules.
// Assumes nothing of its surroundings.
package lswt_pkg;
  typedef enum logic {ST_RUN, ST_HALT} lswt_state_type;
endpackage

// *** hdl/lswt_sync.sv ***
// Two-stage synchroniser with edge detection on the settled level.
// Assumes an asynchronous 1-bit input and the system clock.
`timescale 1ns/1ns
module lswt_sync (
  input  wire logic mclk_in,
  input  wire logic srst_in,
  input  wire logic async_in,
  output logic      level_out,
  output logic      rise_out,
  output logic      fall_out
);
  logic meta_reg;
  logic sync_reg;
  logic prev_reg;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  assign level_out = sync_reg;
  assign rise_out  = sync_reg & ~prev_reg;
  assign fall_out  = ~sync_reg & prev_reg;
endmodule

// *** hdl/lswt_top.sv ***
// Low-speed wakeup timer and tone divider with AXI4-Lite registers.
// Assumes the core pulses halt and other-wake requests on mclk_in.
// How it works
// - Interval from prescaler and timebase fields
// - Wakeup counters advance only while halted
// - Counters reinitialised on each halt entry
// - Wakeup counter value is never readable
// - Other wakeup source abandons current count
// - No automatic return to halt
// - Tone divider runs in every mode
// - Tone output divides the shared low-speed clock
// - Pin driven only with enable and option
// - Tone driver and edge input coexist
// - Edge sense rising only or falling only
// - Selected tone edge wakes the core
// - Field 0x1E, select 0: divide 32, 8
// - Prescaler 11 captures every eight periods
// - Option bit picks low-speed clock source; here bit 3 (SRC) of the control register picks it
// - Route bit feeds low-speed clock to capture
//
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "lswt_map.svh"
module lswt_top (
  input  wire logic        mclk_in,
  input  wire logic        srst_in,
  input  wire logic [7:0]  s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [7:0]  s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  input  wire logic        halt_req_in,
  input  wire logic        wake_other_in,
  input  wire logic        internal_lowspeed_osc_in,
  input  wire logic        external_lowspeed_div_in,
  input  wire logic        tone_option_in,
  input  wire logic        tone_pin_in,
  output logic             tone_pin_out,
  output logic             tone_pin_oe_out,
  output logic             active_halt_out,
  output logic             wakeup_irq_out,
  output logic             tone_exti_out
);
  logic [3:0]  ctrl_reg;
  logic [5:0]  presc_reg;
  logic [3:0]  tbase_reg;
  logic [7:0]  tone_reg;
  logic [5:0]  exti_reg;
  logic [15:0] capt_reg;
  logic [15:0] capt_cnt_reg;
  logic [2:0]  capt_div_reg;
  logic [15:0] tb_cnt_reg;
  logic [2:0]  tone_cnt_reg;
  logic [7:0]  aw_addr_reg;
  logic [7:0]  w_data_reg;
  logic        w_strb_reg;
  logic        aw_held_reg;
  logic        w_held_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        tone_out_reg;
  logic        tone_oe_reg;
  logic        wakeup_irq_reg;
  logic        tone_exti_reg;
  logic [31:0] rd_value;
  logic        rd_hit;
  logic        wr_fire;
  logic        wr_hit;
  logic        rc_level;
  logic        rc_rise;
  logic        ext_rise;
  logic        opt_level;
  logic        pin_rise;
  logic        pin_fall;
  logic        slow_tick;
  logic        halted;
  logic        go_halt;
  logic        presc_pulse;
  logic        wake_hit;
  logic        tone_en;
  logic        tone_pulse;
  logic        tone_edge;
  lswt_pkg::lswt_state_type state_reg;

  function automatic logic addr_known(input logic [7:0] a);
    addr_known = (a == `LSWT_OFF_CTRL) || (a == `LSWT_OFF_PRESC) ||
                 (a == `LSWT_OFF_TBASE) || (a == `LSWT_OFF_TONE) ||
                 (a == `LSWT_OFF_EXTI) || (a == `LSWT_OFF_STAT) ||
                 (a == `LSWT_OFF_CAPT);
  endfunction

  lswt_sync u_rc (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .async_in  (internal_lowspeed_osc_in),
    .level_out (rc_level),
    .rise_out  (rc_rise),
    .fall_out  ()
  );
  lswt_sync u_ext (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .async_in  (external_lowspeed_div_in),
    .level_out (),
    .rise_out  (ext_rise),
    .fall_out  ()
  );
  lswt_sync u_opt (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .async_in  (tone_option_in),
    .level_out (opt_level),
    .rise_out  (),
    .fall_out  ()
  );
  // Pin is read back even while driven, so edges we make are seen
  lswt_sync u_pin (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .async_in  (tone_pin_in),
    .level_out (),
    .rise_out  (pin_rise),
    .fall_out  (pin_fall)
  );

  assign slow_tick = ctrl_reg[`LSWT_CTRL_SRC] ? ext_rise : rc_rise;
  assign halted  = (state_reg == lswt_pkg::ST_HALT);
  assign go_halt = halt_req_in && ctrl_reg[`LSWT_CTRL_WEN];
  assign tone_en = tone_reg[`LSWT_TONE_EN];

  // Bus write path
  assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_hit  = addr_known(aw_addr_reg) && (aw_addr_reg != `LSWT_OFF_STAT) &&
                   (aw_addr_reg != `LSWT_OFF_CAPT);

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg  <= 8'h00;
      w_strb_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `LSWT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid_in && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in[7:0];
        w_strb_reg <= s_axi_wstrb_in[0];
      end
      if (wr_fire)
      begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_hit ? `LSWT_RESP_OKAY : `LSWT_RESP_SLV;
      end
      else if (bvalid_reg && s_axi_bready_in)
      begin
        bvalid_reg  <= 1'b0;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
      end
    end
  end

  // Fields change only here; new values take effect at once, even in the middle of an interval
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      ctrl_reg  <= `LSWT_RST_CTRL;
      presc_reg <= `LSWT_RST_PRESC;
      tbase_reg <= `LSWT_RST_TBASE;
      tone_reg  <= `LSWT_RST_TONE;
      exti_reg  <= `LSWT_RST_EXTI;
    end
    else if (wr_fire && wr_hit && w_strb_reg)
    begin
      case (aw_addr_reg)
        `LSWT_OFF_CTRL:  ctrl_reg  <= w_data_reg[3:0];
        `LSWT_OFF_PRESC: presc_reg <= w_data_reg[5:0];
        `LSWT_OFF_TBASE: tbase_reg <= w_data_reg[3:0];
        `LSWT_OFF_TONE:  tone_reg  <= w_data_reg;
        `LSWT_OFF_EXTI:  exti_reg  <= w_data_reg[5:0];
        default:         ctrl_reg  <= ctrl_reg;
      endcase
    end
  end

  // Bus read path; interval counters are deliberately absent
  always_comb
  begin
    rd_hit = addr_known(s_axi_araddr_in);
    case (s_axi_araddr_in)
      `LSWT_OFF_CTRL:  rd_value = {28'h0000_000, ctrl_reg};
      `LSWT_OFF_PRESC: rd_value = {26'h000_0000, presc_reg};
      `LSWT_OFF_TBASE: rd_value = {28'h0000_000, tbase_reg};
      `LSWT_OFF_TONE:  rd_value = {24'h00_0000, tone_reg};
      `LSWT_OFF_EXTI:  rd_value = {26'h000_0000, exti_reg};
      `LSWT_OFF_STAT:  rd_value = {28'h0000_000, rc_level, opt_level,
                                   tone_out_reg, halted};
      `LSWT_OFF_CAPT:  rd_value = {16'h0000, capt_reg};
      default:         rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= `LSWT_RESP_OKAY;
    end
    else if (s_axi_arvalid_in && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_value;
      rresp_reg   <= rd_hit ? `LSWT_RESP_OKAY : `LSWT_RESP_SLV;
    end
    else if (rvalid_reg && s_axi_rready_in)
    begin
      rvalid_reg  <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // Wakeup chain held in clear outside halt: stops and reinitialises
  lswt_div u_presc (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .clear_in  (!halted),
    .tick_in   (slow_tick),
    .limit_in  (presc_reg),
    .pulse_out (presc_pulse)
  );

  assign wake_hit = presc_pulse &&
                    (tb_cnt_reg == 16'((17'h0_0001 << tbase_reg) - 17'h0_0001));

  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !halted)
      tb_cnt_reg <= 16'h0000;
    else if (presc_pulse)
      tb_cnt_reg <= tb_cnt_reg + 16'h0001;
  end

  // Leaving halt for any reason discards the count; no auto re-entry
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      state_reg      <= lswt_pkg::ST_RUN;
      wakeup_irq_reg <= 1'b0;
    end
    else
    begin
      wakeup_irq_reg <= 1'b0;
      case (state_reg)
        lswt_pkg::ST_RUN:
          if (go_halt)
            state_reg <= lswt_pkg::ST_HALT;
        lswt_pkg::ST_HALT:
          if (wake_hit)
          begin
            state_reg      <= lswt_pkg::ST_RUN;
            wakeup_irq_reg <= 1'b1;
          end
          else if (wake_other_in || tone_edge)
            state_reg <= lswt_pkg::ST_RUN;
        default:
          state_reg <= lswt_pkg::ST_RUN;
      endcase
    end
  end

  // Tone chain: free of the halt state, so it runs in every mode
  lswt_div u_tone (
    .mclk_in   (mclk_in),
    .srst_in   (srst_in),
    .clear_in  (!tone_en),
    .tick_in   (slow_tick),
    .limit_in  ({1'b0, tone_reg[4:0]} + 6'h01),
    .pulse_out (tone_pulse)
  );

  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !tone_en)
      tone_cnt_reg <= 3'h0;
    else if (tone_pulse)
      tone_cnt_reg <= tone_cnt_reg + 3'h1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      tone_out_reg <= 1'b0;
      tone_oe_reg  <= 1'b0;
    end
    else
    begin
      case (tone_reg[7:6])
        2'h0:    tone_out_reg <= tone_en && tone_cnt_reg[2];
        2'h1:    tone_out_reg <= tone_en && tone_cnt_reg[1];
        default: tone_out_reg <= tone_en && tone_cnt_reg[0];
      endcase
      tone_oe_reg <= tone_en && opt_level;
    end
  end

  // Every pin edge of the sense in exti_reg[1:0] is passed on; sense 0 and 3 pass none
  assign tone_edge = ((exti_reg[1:0] == `LSWT_SENSE_RISE) && pin_rise) ||
                     ((exti_reg[1:0] == `LSWT_SENSE_FALL) && pin_fall);

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      tone_exti_reg <= 1'b0;
    else
      tone_exti_reg <= tone_edge;
  end

  // System-clock count over 1, 2, 4 or 8 low-speed periods
  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !ctrl_reg[`LSWT_CTRL_MEAS])
    begin
      capt_cnt_reg <= 16'h0000;
      capt_div_reg <= 3'h0;
      capt_reg     <= 16'h0000;
    end
    else if (rc_rise)
    begin
      if (capt_div_reg == 3'(4'h1 << exti_reg[5:4]) - 3'h1)
      begin
        capt_reg     <= capt_cnt_reg + 16'h0001;
        capt_cnt_reg <= 16'h0000;
        capt_div_reg <= 3'h0;
      end
      else
      begin
        capt_cnt_reg <= capt_cnt_reg + 16'h0001;
        capt_div_reg <= capt_div_reg + 3'h1;
      end
    end
    else if (capt_cnt_reg != 16'hFFFF)
      capt_cnt_reg <= capt_cnt_reg + 16'h0001;
  end

  assign s_axi_awready_out = !aw_held_reg;
  assign s_axi_wready_out  = !w_held_reg;
  assign s_axi_bvalid_out  = bvalid_reg;
  assign s_axi_bresp_out   = bresp_reg;
  assign s_axi_arready_out = arready_reg;
  assign s_axi_rvalid_out  = rvalid_reg;
  assign s_axi_rdata_out   = rdata_reg;
  assign s_axi_rresp_out   = rresp_reg;
  assign tone_pin_out      = tone_out_reg;
  assign tone_pin_oe_out   = tone_oe_reg;
  assign active_halt_out   = halted;
  assign wakeup_irq_out    = wakeup_irq_reg;
  assign tone_exti_out     = tone_exti_reg;

  chk_run_stopped: assert property (@(posedge mclk_in) disable iff (srst_in)
    (state_reg == lswt_pkg::ST_RUN) |=> tb_cnt_reg == 16'h0000)
    else $error("wakeup count moved outside halt");
  chk_entry_from_zero: assert property (@(posedge mclk_in) disable iff (srst_in)
    (!halted && go_halt) |=> halted && tb_cnt_reg == 16'h0000)
    else $error("halt entry did not start from zero");
  chk_halt_needs_enable: assert property (@(posedge mclk_in) disable iff (srst_in)
    (!halted && !ctrl_reg[`LSWT_CTRL_WEN]) |=> !halted)
    else $error("halt entered without wakeup enable");
  chk_other_abandons: assert property (@(posedge mclk_in) disable iff (srst_in)
    (halted && wake_other_in && !wake_hit) |=> !halted ##1 tb_cnt_reg == 16'h0000)
    else $error("other wake kept the count");
  chk_wake_no_return: assert property (@(posedge mclk_in) disable iff (srst_in)
    wakeup_irq_out |-> !halted && $past(halted) ##1 !wakeup_irq_out)
    else $error("wakeup pulse malformed");
  chk_pin_drive_gate: assert property (@(posedge mclk_in) disable iff (srst_in)
    tone_pin_oe_out |-> $past(tone_en) && $past(opt_level))
    else $error("pin driven without enable and option");
  chk_edge_sense: assert property (@(posedge mclk_in) disable iff (srst_in)
    (exti_reg[1:0] == `LSWT_SENSE_FALL && pin_rise) |=> !tone_exti_out)
    else $error("wrong edge raised interrupt");
  chk_tone_in_halt: assert property (@(posedge mclk_in) disable iff (srst_in)
    (tone_pulse && tone_en && halted) |=> tone_cnt_reg == $past(tone_cnt_reg) + 3'h1)
    else $error("tone divider stalled in halt");
endmodule

// *** tb/lswt_core_model.sv ***
// Far-side model: core halt and wake requests, both low-speed oscillators, tone pin wire.
// Assumes the bench calls pulse right after a rising edge of mclk_in.
`timescale 1ns/1ns
module lswt_core_model #(
  parameter int INT_HALF = 400,
  parameter int EXT_HALF = 600
) (
  input  wire logic mclk_in,
  input  wire logic tone_pin_out_in,
  input  wire logic tone_pin_oe_in,
  output logic      halt_req_out,
  output logic      wake_other_out,
  output logic      int_osc_out,
  output logic      ext_osc_out,
  output logic      pin_level_out
);
  logic last_level_reg;

  initial
  begin
    halt_req_out = 1'b0;
    wake_other_out = 1'b0;
    last_level_reg = 1'b0;
    int_osc_out = 1'b0;
    #37;
    forever #INT_HALF int_osc_out = ~int_osc_out;
  end

  // Phase unrelated to the system clock and to the other oscillator
  initial
  begin
    ext_osc_out = 1'b0;
    #71;
    forever #EXT_HALF ext_osc_out = ~ext_osc_out;
  end

  // No pull on the pin: once released it shows the opposite of the last driven level
  always @(posedge mclk_in)
    if (tone_pin_oe_in)
      last_level_reg <= tone_pin_out_in;
  assign pin_level_out = tone_pin_oe_in ? tone_pin_out_in : ~last_level_reg;

  // One-cycle request; the bench sets the wakeup enable bit before a real halt
  task automatic pulse(input bit other);
    if (other)
      wake_other_out <= 1'b1;
    else
      halt_req_out <= 1'b1;
    @(posedge mclk_in);
    wake_other_out <= 1'b0;
    halt_req_out <= 1'b0;
  endtask
endmodule

// *** tb/lswt_top_test.sv ***
// Self-checking bench for the low-speed wakeup timer and tone divider.
// Assumes the design files and the partner model are compiled first.
`timescale 1ns/1ns
`include "lswt_map.svh"
module lswt_top_test;
  localparam int RC_CYC = 8;
  localparam int XT_CYC = 12;
  localparam int EDGES = (3 + 1) * (1 << 2);
  localparam int TONE_CYC = (30 + 2) * 8 * RC_CYC;
  logic        mclk_in, srst_in, awvalid, wvalid, bready, arvalid, rready, option;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0]  bresp, rresp, resp;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, pin_out, pin_oe, halted, irq, exti;
  logic        halt_req, wake_other, int_osc, ext_osc, pin_in;
  int          errors, tests_run, n, k, cnt, first;
  int          sense_tab[4] = '{1, 2, 0, 3};

  lswt_top dut_u (
    .mclk_in(mclk_in), .srst_in(srst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .halt_req_in(halt_req), .wake_other_in(wake_other),
    .internal_lowspeed_osc_in(int_osc), .external_lowspeed_div_in(ext_osc),
    .tone_option_in(option), .tone_pin_in(pin_in), .tone_pin_out(pin_out),
    .tone_pin_oe_out(pin_oe), .active_halt_out(halted), .wakeup_irq_out(irq),
    .tone_exti_out(exti)
  );

  lswt_core_model #(.INT_HALF(RC_CYC * 50), .EXT_HALF(XT_CYC * 50)) model_u (
    .mclk_in(mclk_in), .tone_pin_out_in(pin_out), .tone_pin_oe_in(pin_oe),
    .halt_req_out(halt_req), .wake_other_out(wake_other), .int_osc_out(int_osc),
    .ext_osc_out(ext_osc), .pin_level_out(pin_in)
  );

  always #50 mclk_in = ~mclk_in;

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] seen);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic check_range(input string name, input int lo, input int hi,
                             input logic [31:0] seen);
    tests_run++;
    if (((seen >= lo) && (seen <= hi)) !== 1'b1)
    begin
      errors++;
      $display("unexpected %s: expected %0d to %0d, seen %0d", name, lo, hi, seen);
    end
  endtask

  // Address and data released as each is taken; bready drops once bvalid is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp_r);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    check_val("write response", exp_r, bresp);
    bready <= 1'b0;
    @(posedge mclk_in);
    check_val("write ready after response", 1, awready && wready);
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      if (arvalid && arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk_in);
    check_val("read ready after response", 1, arready);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp_d, input logic [1:0] exp_r);
    logic [31:0] d;
    logic [1:0]  r;
    axi_read(a, d, r);
    check_val("read data", exp_d, d);
    check_val("read response", exp_r, r);
  endtask

  // Cycles from the sampled request until the core leaves halt, with wakeup pulses seen
  task automatic wait_exit(output int c, output int irqs);
    c = 0;
    irqs = 0;
    do
    begin
      @(posedge mclk_in);
      c++;
      if (irq) irqs++;
    end
    while (halted && c < 5000);
  endtask

  task automatic wait_rise(output int c);
    logic p;
    p = pin_out;
    c = 0;
    do
    begin
      @(posedge mclk_in);
      c++;
      if (pin_out && !p) break;
      p = pin_out;
    end
    while (c < 5000);
  endtask

  task automatic count_exti(output int c, output int f);
    int w;
    c = 0;
    f = -1;
    wait_rise(w);
    for (int i = 1; i <= TONE_CYC; i++)
    begin
      @(posedge mclk_in);
      if (exti && f < 0) f = i;
      if (exti) c++;
    end
  endtask

  task automatic summarize();
    $display("Checks run %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    repeat (60000) @(posedge mclk_in);
    errors++;
    summarize();
  end

  initial
  begin
    {mclk_in, awvalid, wvalid, arvalid, option, errors, tests_run} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {bready, rready, srst_in} = 3'h1;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    @(posedge mclk_in);
    rd(`LSWT_OFF_CTRL, 32'h0000_0000, `LSWT_RESP_OKAY);
    rd(`LSWT_OFF_PRESC, 32'h0000_0000, `LSWT_RESP_OKAY);
    rd(`LSWT_OFF_TBASE, 32'h0000_0000, `LSWT_RESP_OKAY);
    rd(`LSWT_OFF_TONE, 32'h0000_001E, `LSWT_RESP_OKAY);
    rd(`LSWT_OFF_EXTI, 32'h0000_0000, `LSWT_RESP_OKAY);
    rd(8'h1C, 32'h0000_0000, `LSWT_RESP_SLV);
    wr(`LSWT_OFF_STAT, 32'h0000_00FF, `LSWT_RESP_SLV);
    wstrb <= 4'h0;
    wr(`LSWT_OFF_PRESC, 32'h0000_003F, `LSWT_RESP_OKAY);
    wstrb <= 4'hF;
    rd(`LSWT_OFF_PRESC, 32'h0000_0000, `LSWT_RESP_OKAY);
    model_u.pulse(0);
    wait_exit(n, k);
    check_range("halt without enable", 1, 1, n);
    wr(`LSWT_OFF_PRESC, 32'h0000_0003, `LSWT_RESP_OKAY);
    wr(`LSWT_OFF_TBASE, 32'h0000_0002, `LSWT_RESP_OKAY);
    for (int s = 0; s < 2; s++)
    begin
      wr(`LSWT_OFF_CTRL, 32'h0000_0001 | (s << 3), `LSWT_RESP_OKAY);
      repeat (40) @(posedge mclk_in);
      model_u.pulse(0);
      wait_exit(n, k);
      check_range("wakeup interval", (EDGES - 1) * (s ? XT_CYC : RC_CYC),
                  EDGES * (s ? XT_CYC : RC_CYC) + 6, n);
      check_val("wakeup pulses", 1, k);
    end
    wr(`LSWT_OFF_CTRL, 32'h0000_0001, `LSWT_RESP_OKAY);
    model_u.pulse(0);
    repeat (60) @(posedge mclk_in);
    model_u.pulse(1);
    wait_exit(n, k);
    check_range("other wake exit", 1, 2, n);
    check_val("pulses on other wake", 0, k);
    model_u.pulse(0);
    wait_exit(n, k);
    check_range("interval after rewake", (EDGES - 1) * RC_CYC, EDGES * RC_CYC + 6, n);
    repeat (300) @(posedge mclk_in);
    check_val("no automatic halt", 0, halted);
    option <= 1'b1;
    wr(`LSWT_OFF_TONE, 32'h0000_007E, `LSWT_RESP_OKAY);
    repeat (6) @(posedge mclk_in);
    check_val("pin enable", 1, pin_oe);
    wait_rise(n);
    wait_rise(n);
    check_range("tone period select 1", TONE_CYC / 2 - 2, TONE_CYC / 2 + 2, n);
    wr(`LSWT_OFF_TONE, 32'h0000_003E, `LSWT_RESP_OKAY);
    // Switching select may leave one odd rise; measure between two later ones
    wait_rise(n);
    wait_rise(n);
    wait_rise(n);
    check_range("tone period", TONE_CYC - 2, TONE_CYC + 2, n);
    for (int s = 0; s < 4; s++)
    begin
      wr(`LSWT_OFF_EXTI, sense_tab[s], `LSWT_RESP_OKAY);
      count_exti(cnt, first);
      check_val("edge events per period", (s < 2) ? 1 : 0, cnt);
      if (s < 2) check_range("edge event offset", s * TONE_CYC / 2,
                             s * TONE_CYC / 2 + 6, first);
    end
    wr(`LSWT_OFF_EXTI, 32'h0000_0001, `LSWT_RESP_OKAY);
    wr(`LSWT_OFF_PRESC, 32'h0000_003F, `LSWT_RESP_OKAY);
    wr(`LSWT_OFF_TBASE, 32'h0000_000F, `LSWT_RESP_OKAY);
    model_u.pulse(0);
    wait_exit(n, k);
    check_range("tone edge wake", 2, TONE_CYC + 8, n);
    check_val("pulses on tone wake", 0, k);
    option <= 1'b0;
    repeat (6) @(posedge mclk_in);
    check_val("pin enable without option", 0, pin_oe);
    wr(`LSWT_OFF_CTRL, 32'h0000_0002, `LSWT_RESP_OKAY);
    wr(`LSWT_OFF_EXTI, 32'h0000_0030, `LSWT_RESP_OKAY);
    repeat (300) @(posedge mclk_in);
    axi_read(`LSWT_OFF_CAPT, got, resp);
    check_range("capture count", 8 * RC_CYC - 2, 8 * RC_CYC + 2, got);
    summarize();
  end
endmodule
